// [shared/spi_reg_pkg.sv]
package spi_reg_pkg;

  localparam int BYTE_BITS  = 8;
  localparam int ADDR_W     = 5;
  localparam int CNT_W      = 5;
  localparam int STATUS_CNT = 4;
  localparam int STATUS_W   = 7;

  // Command byte layout
  localparam int OP_BIT  = 7;
  localparam int ADDR_LO = 0;

  localparam logic OP_READ  = 1'b0;
  localparam logic OP_WRITE = 1'b1;

  // Register indices
  localparam logic [ADDR_W-1:0] IDX_WATCHDOG  = 5'h00;
  localparam logic [ADDR_W-1:0] IDX_STEP_AMP  = 5'h01;
  localparam logic [ADDR_W-1:0] IDX_DRIVE     = 5'h02;
  localparam logic [ADDR_W-1:0] IDX_STATUS_LO = 5'h04;
  localparam logic [ADDR_W-1:0] IDX_STATUS_HI = 5'h07;

  localparam logic [7:0] CTRL_RESET     = 8'h00;
  localparam logic [7:0] UNMAPPED_VALUE = 8'h00;
  localparam logic [7:0] TX_RESET       = 8'hFF;
  localparam logic [6:0] STATUS_RESET   = 7'h00;

  localparam int WARM_BOOT_BIT = 6;

  // Exact length of a valid write packet, in serial clocks
  localparam logic [CNT_W-1:0] WRITE_BITS = 5'h10;
  localparam logic [CNT_W-1:0] CNT_MAX    = 5'h1F;
  localparam logic [2:0]       LAST_BIT   = 3'h7;

  typedef struct packed {
    logic       watchdogArm;
    logic [3:0] watchdogPeriodSel;
    logic [2:0] spare;
  } watchdog_control_s;

  typedef struct packed {
    logic [2:0] stepResolution;
    logic [4:0] amplitudeLevel;
  } step_amplitude_config_s;

  typedef struct packed {
    logic       rotationSense;
    logic       stepPulsePolarity;
    logic [1:0] spare;
    logic       chopperFreqSel;
    logic       chopperJitter;
    logic [1:0] slopeSel;
  } drive_config_s;

  typedef enum logic [1:0] {
    PH_COMMAND = 2'b01,
    PH_DATA    = 2'b10
  } phase_e;

endpackage

// [verilog/input_sync.sv]
`timescale 1ns/1ps
module input_sync #(
  parameter int               WIDTH    = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input  wire logic             ref_clk,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] stage1;

  // First stage feeds only the second
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      stage1  <= RESET_VAL;
      syncOut <= RESET_VAL;
    end else begin
      stage1  <= asyncIn;
      syncOut <= stage1;
    end
  end

endmodule // input_sync

// [verilog/status_bank.sv]
`timescale 1ns/1ps
module status_bank #(
  parameter int COUNT = spi_reg_pkg::STATUS_CNT,
  parameter int WIDTH = spi_reg_pkg::STATUS_W
) (
  input  wire logic                        ref_clk,
  input  wire logic                        reset,
  input  wire logic                        csHigh,
  input  wire logic                        csRise,
  input  wire logic [COUNT-1:0][WIDTH-1:0] statusEvents,
  input  wire logic                        warmBootSet,
  input  wire logic                        warmBootClear,
  input  wire logic [1:0]                  readSel,
  input  wire logic                        readMark,
  output logic      [7:0]                  readValue,
  output logic                             errorFlagN,
  output logic                             warmBootFlag
);

  logic [COUNT-1:0][WIDTH-1:0] status;
  logic [COUNT-1:0][WIDTH-1:0] next_status;
  logic [COUNT-1:0]            readMask;
  logic                        warmPending;
  logic [WIDTH-1:0]            shown;

  function automatic logic [7:0] withParity(input logic [WIDTH-1:0] d);
    withParity = {^d, d};
  endfunction

  // Read marks are held until the frame ends
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      readMask <= '0;
    end else if (csRise) begin
      readMask <= '0;
    end else if (readMark) begin
      readMask[readSel] <= 1'b1;
    end
  end

  // New events win over the clear of the same cycle
  always_comb begin
    for (int i = 0; i < COUNT; i++) begin
      next_status[i] = ((csRise && readMask[i]) ? '0 : status[i])
                       | statusEvents[i];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      status     <= '0;
      errorFlagN <= 1'b1;
    end else if (csHigh) begin
      status     <= next_status;
      errorFlagN <= ~(|next_status);
    end
  end

  // Watchdog resets while selected wait for the bus to go idle
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      warmPending  <= 1'b0;
      warmBootFlag <= 1'b0;
    end else if (csHigh) begin
      warmPending  <= 1'b0;
      warmBootFlag <= warmBootSet | warmPending
                      | (warmBootFlag & ~warmBootClear);
    end else if (warmBootSet) begin
      warmPending <= 1'b1;
    end
  end

  always_comb begin
    shown = status[readSel];
    if (readSel == 2'h0) begin
      shown[spi_reg_pkg::WARM_BOOT_BIT] = status[0][spi_reg_pkg::WARM_BOOT_BIT]
                                          | warmBootFlag;
    end
    readValue = withParity(shown);
  end

endmodule // status_bank

// [verilog/spi_slave_register_port.sv]
`timescale 1ns/1ps
module spi_slave_register_port (
  input  wire logic                               ref_clk,
  input  wire logic                               reset,
  input  wire logic                               spiClk,
  input  wire logic                               chipSelectN,
  input  wire logic                               serialIn,
  input  wire logic                               serialOutIn,
  output logic                                    serialOut,
  output logic                                    serialOutOe,
  input  wire logic [spi_reg_pkg::STATUS_CNT-1:0]
                    [spi_reg_pkg::STATUS_W-1:0]   statusEvents,
  input  wire logic                               warmBootSet,
  output logic                                    errorFlagN,
  output logic                                    warmBootFlag,
  output logic                                    watchdogKick,
  output spi_reg_pkg::watchdog_control_s          watchdogControl,
  output spi_reg_pkg::step_amplitude_config_s     stepAmplitudeConfig,
  output spi_reg_pkg::drive_config_s              driveConfig
);

  logic [2:0]                     syncPins;
  logic                           clkNow;
  logic                           csNow;
  logic                           dataNow;
  logic                           clkPrev;
  logic                           csPrev;
  logic                           clkRise;
  logic                           clkFall;
  logic                           csFall;
  logic                           csRise;
  logic                           active;
  logic [7:0]                     rxShift;
  logic [7:0]                     rxByte;
  logic [7:0]                     txShift;
  logic [spi_reg_pkg::CNT_W-1:0]  bitCount;
  logic [2:0]                     bitInByte;
  logic                           loadPending;
  logic [spi_reg_pkg::ADDR_W-1:0] lastAddr;
  spi_reg_pkg::phase_e            phase;
  logic                           writePending;
  logic [spi_reg_pkg::ADDR_W-1:0] writeAddr;
  logic [7:0]                     writeData;
  logic                           commitOk;
  logic                           statusSel;
  logic [7:0]                     statusValue;
  logic [7:0]                     readValue;
  logic                           warmBootClear;

  function automatic logic isStatus(
    input logic [spi_reg_pkg::ADDR_W-1:0] a
  );
    isStatus = (a >= spi_reg_pkg::IDX_STATUS_LO)
               && (a <= spi_reg_pkg::IDX_STATUS_HI);
  endfunction

  input_sync #(
    .WIDTH     (3),
    .RESET_VAL (3'h2)
  ) pinSync (
    .ref_clk (ref_clk),
    .reset   (reset),
    .asyncIn ({spiClk, chipSelectN, serialIn}),
    .syncOut (syncPins)
  );

  assign clkNow  = syncPins[2];
  assign csNow   = syncPins[1];
  assign dataNow = syncPins[0];

  // Edge history taken from synchronised copies only
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      clkPrev <= 1'b0;
      csPrev  <= 1'b1;
    end else begin
      clkPrev <= clkNow;
      csPrev  <= csNow;
    end
  end

  assign active  = ~csNow;
  assign clkRise = active & clkNow & ~clkPrev;
  assign clkFall = active & ~clkNow & clkPrev;
  assign csFall  = ~csNow & csPrev;
  assign csRise  = csNow & ~csPrev;
  assign rxByte  = {rxShift[6:0], dataNow};

  // Receive shifter and packet length, saturating so long packets stay long
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rxShift  <= 8'h00;
      bitCount <= '0;
    end else if (csFall) begin
      bitCount <= '0;
    end else if (clkRise) begin
      rxShift <= rxByte;
      if (bitCount != spi_reg_pkg::CNT_MAX) begin
        bitCount <= bitCount + 5'h01;
      end
    end
  end

  // Byte position wraps freely, so long read chains keep their framing
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      bitInByte <= 3'h0;
    end else if (csFall) begin
      bitInByte <= 3'h0;
    end else if (clkRise) begin
      bitInByte <= bitInByte + 3'h1;
    end
  end

  // Byte framing: a command byte, then data only after a write command
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      phase        <= spi_reg_pkg::PH_COMMAND;
      lastAddr     <= '0;
      writePending <= 1'b0;
      writeAddr    <= '0;
      writeData    <= 8'h00;
      loadPending  <= 1'b0;
    end else if (csFall) begin
      phase        <= spi_reg_pkg::PH_COMMAND;
      writePending <= 1'b0;
      loadPending  <= 1'b0;
    end else if (clkRise && bitInByte == spi_reg_pkg::LAST_BIT) begin
      loadPending <= 1'b1;
      unique case (phase)
        spi_reg_pkg::PH_COMMAND: begin
          lastAddr <= rxByte[spi_reg_pkg::ADDR_LO +: spi_reg_pkg::ADDR_W];
          if (rxByte[spi_reg_pkg::OP_BIT] == spi_reg_pkg::OP_WRITE) begin
            phase     <= spi_reg_pkg::PH_DATA;
            writeAddr <= rxByte[spi_reg_pkg::ADDR_LO +: spi_reg_pkg::ADDR_W];
          end else begin
            phase <= spi_reg_pkg::PH_COMMAND;
          end
        end
        spi_reg_pkg::PH_DATA: begin
          phase        <= spi_reg_pkg::PH_COMMAND;
          writeData    <= rxByte;
          writePending <= 1'b1;
        end
      endcase
    end else if (clkFall) begin
      loadPending <= 1'b0;
    end
  end

  assign statusSel = isStatus(lastAddr);

  always_comb begin
    if (lastAddr == spi_reg_pkg::IDX_WATCHDOG) begin
      readValue = watchdogControl;
    end else if (lastAddr == spi_reg_pkg::IDX_STEP_AMP) begin
      readValue = stepAmplitudeConfig;
    end else if (lastAddr == spi_reg_pkg::IDX_DRIVE) begin
      readValue = driveConfig;
    end else if (statusSel) begin
      readValue = statusValue;
    end else begin
      readValue = spi_reg_pkg::UNMAPPED_VALUE;
    end
  end

  // Shifter is only reloaded at a byte end, so a new frame starts stale
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      txShift <= spi_reg_pkg::TX_RESET;
    end else if (clkFall) begin
      if (loadPending) begin
        txShift <= readValue;
      end else begin
        txShift <= {txShift[6:0], 1'b1};
      end
    end
  end

  // Open drain: only a low is driven
  assign serialOut   = 1'b0;
  assign serialOutOe = active & ~txShift[7];

  status_bank #(
    .COUNT (spi_reg_pkg::STATUS_CNT),
    .WIDTH (spi_reg_pkg::STATUS_W)
  ) statusBank (
    .ref_clk       (ref_clk),
    .reset         (reset),
    .csHigh        (csNow),
    .csRise        (csRise),
    .statusEvents  (statusEvents),
    .warmBootSet   (warmBootSet),
    .warmBootClear (warmBootClear),
    .readSel       (lastAddr[1:0]),
    .readMark      (clkFall & loadPending & statusSel),
    .readValue     (statusValue),
    .errorFlagN    (errorFlagN),
    .warmBootFlag  (warmBootFlag)
  );

  assign commitOk = csRise & writePending
                    & (bitCount == spi_reg_pkg::WRITE_BITS);

  // Status indices are absent here, so such writes fall through
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      watchdogControl     <= spi_reg_pkg::CTRL_RESET;
      stepAmplitudeConfig <= spi_reg_pkg::CTRL_RESET;
      driveConfig         <= spi_reg_pkg::CTRL_RESET;
    end else if (commitOk) begin
      unique case (writeAddr)
        spi_reg_pkg::IDX_WATCHDOG: watchdogControl     <= writeData;
        spi_reg_pkg::IDX_STEP_AMP: stepAmplitudeConfig <= writeData;
        spi_reg_pkg::IDX_DRIVE:    driveConfig         <= writeData;
        default: ;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      watchdogKick  <= 1'b0;
      warmBootClear <= 1'b0;
    end else begin
      watchdogKick  <= commitOk & (writeAddr == spi_reg_pkg::IDX_WATCHDOG)
                       & writeData[7];
      warmBootClear <= commitOk & (writeAddr == spi_reg_pkg::IDX_WATCHDOG)
                       & ~writeData[7];
    end
  end

  // Loopback of the output pin is not needed
  logic unusedOut;
  assign unusedOut = serialOutIn;

endmodule // spi_slave_register_port

// [testbench/spi_port_props.sv]
`timescale 1ns/1ps
module spi_port_props (
  input wire logic                           ref_clk,
  input wire logic                           reset,
  input wire logic                           chipSelectN,
  input wire logic                           serialOutOe,
  input wire logic                           errorFlagN,
  input wire logic                           warmBootFlag,
  input wire logic                           watchdogKick,
  input spi_reg_pkg::watchdog_control_s      watchdogControl,
  input spi_reg_pkg::step_amplitude_config_s stepAmplitudeConfig,
  input spi_reg_pkg::drive_config_s          driveConfig
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  wire logic [23:0] ctrl = {watchdogControl, stepAmplitudeConfig, driveConfig};

  // Six cycles so the synchroniser lag cannot excuse a change
  property p_err_hold;
    !chipSelectN [*6] |-> $stable(errorFlagN);
  endproperty
  property p_flag_hold;
    !chipSelectN [*6] |-> $stable(warmBootFlag);
  endproperty
  property p_ctrl_hold;
    !chipSelectN [*6] |-> $stable(ctrl);
  endproperty
  property p_ctrl_when;
    $changed(ctrl) |-> chipSelectN && $past(chipSelectN, 2);
  endproperty
  property p_oe_idle;
    chipSelectN [*4] |-> !serialOutOe;
  endproperty
  property p_kick;
    watchdogKick |-> watchdogControl.watchdogArm ##1 !watchdogKick;
  endproperty
  property p_warm_clear;
    $fell(warmBootFlag) |-> !watchdogControl.watchdogArm && chipSelectN;
  endproperty
  property p_reset_vals;
    $fell(reset) |-> ctrl == 24'h0 && errorFlagN && !warmBootFlag;
  endproperty

  a_err_hold: assert property (p_err_hold)
    else $error("error flag moved while selected");
  a_flag_hold: assert property (p_flag_hold)
    else $error("warm boot flag moved while selected");
  a_ctrl_hold: assert property (p_ctrl_hold)
    else $error("control register moved while selected");
  a_ctrl_when: assert property (p_ctrl_when)
    else $error("control register moved without deselect");
  a_oe_idle: assert property (p_oe_idle)
    else $error("data line driven while deselected");
  a_kick: assert property (p_kick)
    else $error("bad watchdog restart pulse");
  a_warm_clear: assert property (p_warm_clear)
    else $error("warm boot flag cleared without disarm");
  a_reset_vals: assert property (p_reset_vals)
    else $error("bad values after reset");

  c_kick: cover property (watchdogKick);
  c_err: cover property ($fell(errorFlagN));
  c_warm: cover property ($fell(warmBootFlag));
endmodule // spi_port_props

bind spi_slave_register_port spi_port_props spi_port_props_i (
  .ref_clk, .reset, .chipSelectN, .serialOutOe, .errorFlagN, .warmBootFlag,
  .watchdogKick, .watchdogControl, .stepAmplitudeConfig, .driveConfig
);

// [testbench/spi_master_model.sv]
`timescale 1ns/1ps
module spi_master_model (
  output logic      spiClk,
  output logic      chipSelectN,
  output logic      serialIn,
  input  wire logic sdoLine
);
  localparam int HALF = 32;
  initial begin
    spiClk = 1'b0;
    chipSelectN = 1'b1;
    serialIn = 1'b1;
  end
  // Sends tx[n-1:0]; long gap lets status settle before the next frame
  task automatic xfer(input logic [63:0] tx, input int n,
                      output logic [63:0] rx);
    rx = '0;
    chipSelectN = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      serialIn = tx[i];
      #HALF spiClk = 1'b1;
      rx = {rx[62:0], sdoLine};
      #HALF spiClk = 1'b0;
    end
    #HALF chipSelectN = 1'b1;
    serialIn = ~serialIn;
    #(10 * HALF);
  endtask
endmodule // spi_master_model

// [testbench/spi_slave_register_port_tb.sv]
`timescale 1ns/1ps
module spi_slave_register_port_tb;
  localparam logic RD = spi_reg_pkg::OP_READ;
  localparam logic WR = spi_reg_pkg::OP_WRITE;
  logic                                ref_clk;
  logic                                reset;
  logic                                warmBootSet;
  logic [3:0][6:0]                     statusEvents;
  wire logic                           spiClk;
  wire logic                           chipSelectN;
  wire logic                           serialIn;
  logic                                serialOut;
  logic                                serialOutOe;
  logic                                errorFlagN;
  logic                                warmBootFlag;
  logic                                watchdogKick;
  spi_reg_pkg::watchdog_control_s      watchdogControl;
  spi_reg_pkg::step_amplitude_config_s stepAmplitudeConfig;
  spi_reg_pkg::drive_config_s          driveConfig;
  wire logic                           sdoLine = serialOutOe ? serialOut : 1'b1;
  int                                  bad_count, cmp_count, kicks, idx, k;
  logic [7:0]                          shadow [3];
  logic [63:0]                         rx;
  logic [7:0]                          d, old;
  logic [6:0]                          ev;

  spi_slave_register_port spi_slave_register_port_i (
    .ref_clk, .reset, .spiClk, .chipSelectN, .serialIn,
    .serialOutIn(sdoLine), .serialOut, .serialOutOe, .statusEvents,
    .warmBootSet, .errorFlagN, .warmBootFlag, .watchdogKick,
    .watchdogControl, .stepAmplitudeConfig, .driveConfig
  );
  spi_master_model spi_master_model_i (
    .spiClk, .chipSelectN, .serialIn, .sdoLine
  );

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) if (watchdogKick === 1'b1) kicks++;

  function automatic logic [7:0] cmd(input logic op, input int i);
    return {op, 2'b00, 5'(i)};
  endfunction
  function automatic logic [7:0] withParity(input logic [6:0] v);
    return {^v, v};
  endfunction
  function automatic logic [7:0] ctrlOut(input int i);
    if (i == 0) return 8'(watchdogControl);
    if (i == 1) return 8'(stepAmplitudeConfig);
    return 8'(driveConfig);
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic [63:0] tx, input int n);
    spi_master_model_i.xfer(tx, n, rx);
  endtask
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    reset = 1'b1;
    warmBootSet = 1'b0;
    statusEvents = '0;
    bad_count = 0;
    cmp_count = 0;
    kicks = 0;
    shadow = '{8'h00, 8'h00, 8'h00};
    void'($urandom(32'hF44FEAA7));
    repeat (12) @(posedge ref_clk);
    #1 reset = 1'b0;
    repeat (8) @(posedge ref_clk);
    for (int i = 0; i < 4; i++) begin
      if (i < 3) chk(ctrlOut(i), spi_reg_pkg::CTRL_RESET);
      xfer({cmd(RD, i), 8'h00}, 16);
      if (i == 0) chk(rx[15:8], spi_reg_pkg::TX_RESET);
      chk(rx[7:0], spi_reg_pkg::CTRL_RESET);
    end
    $display("test reset done");
    for (int n = 0; n < 12; n++) begin
      idx = n < 3 ? n : $urandom % 3;
      d = n < 3 ? 8'hFF : 8'($urandom);
      old = shadow[idx];
      k = kicks;
      xfer({cmd(WR, idx), d}, 16);
      chk(rx[7:0], old);
      shadow[idx] = d;
      chk(ctrlOut(idx), d);
      chk(8'(kicks - k), {7'h00, idx == 0 && d[7]});
      xfer({cmd(RD, idx), 8'h00}, 16);
      chk(rx[15:8], old);
      chk(rx[7:0], d);
    end
    chk({watchdogControl.watchdogArm, watchdogControl.watchdogPeriodSel,
         3'h0}, shadow[0] & 8'hF8);
    chk({stepAmplitudeConfig.stepResolution,
         stepAmplitudeConfig.amplitudeLevel}, shadow[1]);
    chk({driveConfig.rotationSense, driveConfig.stepPulsePolarity, 2'h0,
         driveConfig.chopperFreqSel, driveConfig.chopperJitter,
         driveConfig.slopeSel}, shadow[2] & 8'hCF);
    xfer({cmd(RD, 0), cmd(RD, 1), cmd(RD, 2), cmd(RD, 0), 8'h00}, 40);
    chk(rx[31:24], shadow[0]);
    chk(rx[23:16], shadow[1]);
    chk(rx[15:8], shadow[2]);
    chk(rx[7:0], shadow[0]);
    $display("test write and read done");
    for (int n = 0; n < 6; n++) begin
      d = 8'($urandom);
      if (n < 2) xfer({cmd(WR, n), d} >> 1, 15);
      else if (n < 4) xfer({cmd(WR, n - 2), d, 1'b0}, 17);
      else xfer({cmd(WR, n + 2), d}, 16);
      for (int i = 0; i < 3; i++) chk(ctrlOut(i), shadow[i]);
      chk({7'h00, errorFlagN}, 8'h01);
    end
    $display("test refused writes done");
    // Events rise mid-frame and must wait for the deselect
    for (int n = 0; n < 4; n++) begin
      ev = n == 0 ? 7'h7F : 7'($urandom) | 7'h01;
      fork
        xfer({cmd(RD, 3), 8'h00}, 16);
        begin
          repeat (20) @(posedge ref_clk);
          #1 statusEvents[n] = ev;
          repeat (20) @(posedge ref_clk);
          chk({7'h00, errorFlagN}, 8'h01);
        end
      join
      @(posedge ref_clk);
      #1 statusEvents = '0;
      repeat (4) @(posedge ref_clk);
      chk({7'h00, errorFlagN}, 8'h00);
      xfer({cmd(RD, n + 4), 8'h00}, 16);
      chk(rx[7:0], withParity(ev));
      if (rx[7] !== ^rx[6:0]) xfer({cmd(RD, n + 4), 8'h00}, 16);
      chk({7'h00, errorFlagN}, 8'h01);
      xfer({cmd(RD, n + 4), 8'h00}, 16);
      chk(rx[7:0], 8'h00);
    end
    $display("test status done");
    // Set while selected is held back until the deselect
    fork
      xfer({cmd(RD, 3), 8'h00}, 16);
      begin
        repeat (20) @(posedge ref_clk);
        #1 warmBootSet = 1'b1;
        @(posedge ref_clk);
        #1 warmBootSet = 1'b0;
        repeat (4) @(posedge ref_clk);
        chk({7'h00, warmBootFlag}, 8'h00);
      end
    join
    xfer({cmd(RD, 4), 8'h00}, 16);
    chk(rx[7:0], withParity(7'h40));
    for (int n = 1; n >= 0; n--) begin
      d = {1'(n), 7'($urandom)};
      xfer({cmd(WR, 0), d}, 16);
      chk({7'h00, warmBootFlag}, {7'h00, 1'(n)});
    end
    $display("test warm boot done");
    wrap_up();
  end

  initial begin
    #200000;
    bad_count++;
    $display("ERROR t=%0t run did not finish", $time);
    wrap_up();
  end
endmodule // spi_slave_register_port_tb
